// ### tb.sv
`timescale 1ns/1ps

module tb;
  import vmi_pkg::*;
  logic mclk, sys_rst, loc_req, loc_wr, loc_rdy, loc_ack, loc_err, berr_en, oth_go;
  logic [1:0] loc_size, arb_mode, dly;
  logic [31:0] loc_addr, loc_wdata, loc_rdata, vme_d_i, vme_d_o;
  logic [3:0] arb_bg_n;
  logic [31:1] vme_a_o;
  logic [5:0] vme_am_o;
  logic lw_n, wr_n, as_n, ds0_n, ds1_n, c_oe, d_oe, dtack_n, berr_n, bg_out_n;
  logic br_o, br_oe, bb_o, bb_oe, oth_br_n, oth_busy, as_prev;
  logic [33:0] q_ack[$];
  logic [73:0] q_bus[$];
  int errors, n_tests;
  wire as_w = c_oe ? as_n : 1'b1;
  wire bbsy_w = ~(bb_oe | oth_busy);

  vmi_master i_vmi_master (.mclk(mclk), .sys_rst(sys_rst), .loc_req(loc_req), .loc_addr(loc_addr),
    .loc_wr(loc_wr), .loc_size(loc_size), .loc_wdata(loc_wdata), .loc_rdy(loc_rdy), .loc_ack(loc_ack),
    .loc_err(loc_err), .loc_rdata(loc_rdata), .sysctl_en(1'b1), .arb_mode(arb_mode),
    .arb_br_n({~br_oe, 2'b11, oth_br_n}), .arb_bg_n(arb_bg_n), .vme_a_o(vme_a_o), .vme_am_o(vme_am_o),
    .vme_lword_n_o(lw_n), .vme_write_n_o(wr_n), .vme_as_n_o(as_n), .vme_ds0_n_o(ds0_n),
    .vme_ds1_n_o(ds1_n), .vme_ctl_oe(c_oe), .vme_d_i(vme_d_i), .vme_d_o(vme_d_o), .vme_d_oe(d_oe),
    .vme_as_n_i(as_w), .vme_dtack_n(dtack_n), .vme_berr_n(berr_n), .vme_bg_in_n(arb_bg_n[3]),
    .vme_bg_out_n(bg_out_n), .vme_br_n_i(~br_oe), .vme_br_o(br_o), .vme_br_oe(br_oe),
    .vme_bbsy_n_i(bbsy_w), .vme_bbsy_o(bb_o), .vme_bbsy_oe(bb_oe));

  vmi_bus_partner i_vmi_bus_partner (.mclk(mclk), .sys_rst(sys_rst), .as_n(as_w), .ds_n(ds0_n & ds1_n),
    .addr(vme_a_o), .dly(dly), .berr_en(berr_en), .oth_go(oth_go), .oth_bg_n(arb_bg_n[0]),
    .bbsy_n(bbsy_w), .dtack_n(dtack_n), .berr_n(berr_n), .d(vme_d_i), .oth_br_n(oth_br_n),
    .oth_busy(oth_busy));

  // Lane code {refused, lword_n, a1, ds1_n, ds0_n}
  function automatic logic [4:0] lane_of(input logic [1:0] sz, input logic [1:0] a);
    case (sz)
      2'd0: return {2'b01, a[1], a[0], ~a[0]};
      2'd1: return (a == 2'd1) ? 5'h00 : {a[0], 1'b1, a[1], 2'b00};
      2'd2: return (a == 2'd0) ? 5'h01 : ((a == 2'd1) ? 5'h02 : 5'h10);
      default: return (a == 2'd0) ? 5'h00 : 5'h10;
    endcase
  endfunction : lane_of

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_code(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_data({16'h0000, got}, {16'h0000, exp}, what);
  endtask : cmp_code

  task automatic issue(input logic [31:0] a, input logic w, input logic [1:0] sz);
    logic [4:0] ln;
    logic [31:0] wd;
    logic [5:0] am;
    int n;
    ln = lane_of(sz, a[1:0]);
    wd = $urandom;
    am = (a[31:16] == 16'hFFFF) ? 6'h29 : ((a[31:24] == 8'hFF) ? 6'h39 : 6'h09);
    n = 0;
    // A refusal answers at once; earlier bus results come back first so answers stay in order
    while (ln[4] && q_ack.size() != 0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    @(negedge mclk);
    while (loc_rdy !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 500) begin
      errors++;
      $display("CHECK FAILED %0t request slot never freed", $time);
    end
    @(posedge mclk);
    loc_req <= 1'b1;
    loc_addr <= a;
    loc_wr <= w;
    loc_size <= sz;
    loc_wdata <= wd;
    @(posedge mclk);
    loc_req <= 1'b0;
    if ((a & 32'hFF80_0000) != 32'h0000_0000) begin
      q_ack.push_back({ln[4] | berr_en, w, {a[31:2], 2'b00} ^ 32'hC3C3_3C3C});
      if (!ln[4]) q_bus.push_back({w, wd, ~w, am, ln[3:0], a[31:2]});
    end
  endtask : issue

  task automatic drain();
    int n;
    n = 0;
    while (q_ack.size() != 0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    repeat (4) @(posedge mclk);
    cmp_code(16'(q_ack.size()), 16'h0000, "results left over");
  endtask : drain

  task automatic stop_test();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Model results popped at each finished access
  always @(negedge mclk) begin
    logic [33:0] e;
    logic [73:0] b;
    as_prev <= as_n;
    if (!sys_rst && loc_ack === 1'b1) begin
      e = q_ack.size() ? q_ack.pop_front() : 34'h3_0000_0000;
      cmp_code(16'(loc_err), 16'(e[33]), "error flag");
      if (!e[32] && !e[33]) cmp_data(loc_rdata, e[31:0], "read data");
    end
    if (!sys_rst && as_n === 1'b0 && as_prev === 1'b1) begin
      b = q_bus.size() ? q_bus.pop_front() : 74'h0;
      cmp_code(16'({wr_n, vme_am_o, lw_n, vme_a_o[1], ds1_n, ds0_n}), 16'(b[40:30]), "mode and lanes");
      cmp_data({vme_a_o[31:2], 2'b00}, {b[29:0], 2'b00}, "address");
      cmp_code(16'({c_oe, d_oe, br_o, bb_o}), 16'({1'b1, b[73], 2'b00}), "drive enables");
      if (b[73]) cmp_data(vme_d_o, b[72:41], "write data");
    end
  end

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    #(40 * 40000);
    errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    {loc_req, loc_wr, berr_en, oth_go} = 4'b0000;
    {loc_size, arb_mode, dly} = 6'h00;
    {loc_addr, loc_wdata} = 64'h0;
    errors = 0;
    n_tests = 0;
    void'($urandom(8259));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    // all sizes and phases, three address ranges, back to back
    for (int i = 0; i < 48; i++) begin
      dly <= 2'($urandom_range(3));
      issue({(i % 3 == 2) ? 8'($urandom_range(254, 1)) : 8'hFF, (i % 3 == 1) ? 8'hFF : 8'($urandom),
        14'($urandom), i[1:0]}, i[4], i[3:2]);
    end
    drain();
    berr_en <= 1'b1;
    issue(32'h4000_0100 | 32'($urandom_range(255)) << 8, 1'b0, 2'd3);
    drain();
    berr_en <= 1'b0;
    // local window is never sent to the bus
    issue(32'h0012_3400, 1'b0, 2'd3);
    repeat (20) @(posedge mclk);
    cmp_code(16'(loc_rdy), 16'h0001, "slot after local access");
    // each arbiter mode against a rival
    for (int m = 0; m < 3; m++) begin
      arb_mode <= 2'(m);
      oth_go <= 1'b1;
      @(posedge mclk);
      oth_go <= 1'b0;
      issue({8'h80, 24'($urandom)} & 32'hFFFF_FFFC, 1'b0, 2'd3);
      issue({8'h81, 24'($urandom)} & 32'hFFFF_FFFC, 1'b1, 2'd1);
      drain();
    end
    stop_test();
  end
endmodule : tb

bind vmi_master vmi_master_asserts i_chk (.mclk(mclk), .sys_rst(sys_rst), .loc_rdy(loc_rdy),
  .loc_ack(loc_ack), .loc_err(loc_err), .sysctl_en(sysctl_en), .arb_mode(arb_mode), .arb_bg_n(arb_bg_n),
  .vme_as_n_o(vme_as_n_o), .vme_ctl_oe(vme_ctl_oe), .vme_dtack_n(vme_dtack_n), .vme_bg_in_n(vme_bg_in_n),
  .vme_bg_out_n(vme_bg_out_n),
  .vme_br_oe(vme_br_oe), .vme_bbsy_n_i(vme_bbsy_n_i), .vme_bbsy_oe(vme_bbsy_oe));

// ### vmi_arbiter.sv
`timescale 1ns/1ps
`include "vmi_consts.svh"

module vmi_arbiter
  import vmi_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic arb_en, // System controller slot enable
  input wire logic [1:0] arb_mode, // Arbitration mode
  input wire logic [3:0] br_n, // Bus request lines, low
  input wire logic bbsy_n, // Bus busy line, low
  output logic [3:0] bg_n // Bus grant daisy outputs, low
);

  vmi_arb_st_t st_q, st_d;
  logic [1:0] win;
  logic [1:0] last_q;
  logic found;
  logic [3:0] bg_q;
  logic [1:0] idx;

  wire [3:0] req = ~br_n;
  wire any_req = found & arb_en;

  // ----------------------------------------------------------------------------
  // Winner selection
  // ----------------------------------------------------------------------------
  // R7 three arbitration modes
  always_comb begin
    win = 2'd0;
    found = 1'b0;
    idx = 2'd0;
    unique case (arb_mode)
      ARB_PRI: begin
        for (int i = 0; i < 4; i++) begin
          if (req[i]) begin
            win = 2'(i);
            found = 1'b1;
          end
        end
      end
      ARB_SGL: begin
        // Only the top level is served; the daisy chain orders masters there
        win = 2'd3;
        found = req[3];
      end
      default: begin
        // Round robin: search upward from the level after the last winner
        for (int k = 1; k <= 4; k++) begin
          idx = 2'(last_q + 2'(k));
          if (req[idx] && !found) begin
            win = idx;
            found = 1'b1;
          end
        end
      end
    endcase
  end

  // Grant only while the bus is idle, withdraw once the new owner shows busy
  // R8 grant after busy released
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      AR_IDLE: if (any_req && bbsy_n) st_d = AR_GRANT;
      AR_GRANT: begin
        if (!bbsy_n) st_d = AR_BUSY;
        else if (br_n[last_q]) st_d = AR_IDLE;
      end
      AR_BUSY: if (bbsy_n) st_d = AR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= AR_IDLE;
      last_q <= 2'd0;
    end else begin
      st_q <= st_d;
      if (st_q == AR_IDLE && st_d == AR_GRANT) last_q <= win;
    end
  end

  // ----------------------------------------------------------------------------
  // Per-level grant drivers
  // ----------------------------------------------------------------------------
  // One register for all levels, so each grant bit has a single writer
  logic [3:0] bg_d;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bg
      assign bg_d[g] = ~(st_d == AR_GRANT && ((st_q == AR_IDLE) ? (win == 2'(g)) : (last_q == 2'(g))));
    end
  endgenerate

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bg_q <= `VMI_RST_GRANT_N;
    end else begin
      bg_q <= bg_d;
    end
  end

  assign bg_n = bg_q;

endmodule : vmi_arbiter

// ### vmi_bus_partner.sv
`timescale 1ns/1ps

module vmi_bus_partner (
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic as_n, // strobe wire
  input wire logic ds_n, // both data strobes high
  input wire logic [31:1] addr, // address
  input wire logic [1:0] dly, // extra wait
  input wire logic berr_en, // answer error
  input wire logic oth_go, // other wants bus
  input wire logic oth_bg_n, // other grant
  input wire logic bbsy_n, // busy wire
  output logic dtack_n, // acknowledge
  output logic berr_n, // bus error
  output logic [31:0] d, // read data
  output logic oth_br_n, // other request
  output logic oth_busy // other holds busy
);
  logic [2:0] cnt_q;
  logic [2:0] own_q;

  // Released lines float up through the terminators
  assign d = (dtack_n) ? 32'hFFFF_FFFF : {addr[31:2], 2'b00} ^ 32'hC3C3_3C3C;

  // answer after strobes, hold until strobes rise
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 3'h0;
      dtack_n <= 1'b1;
      berr_n <= 1'b1;
    end else if (!as_n && !ds_n) begin
      cnt_q <= cnt_q + 3'h1;
      dtack_n <= !(cnt_q >= {1'b0, dly} && !berr_en);
      berr_n <= !(cnt_q >= {1'b0, dly} && berr_en);
    end else begin
      cnt_q <= 3'h0;
      dtack_n <= 1'b1;
      berr_n <= 1'b1;
    end
  end

  // other master waits for idle bus, then holds busy five cycles
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      oth_br_n <= 1'b1;
      oth_busy <= 1'b0;
      own_q <= 3'h0;
    end else if (oth_busy) begin
      own_q <= own_q + 3'h1;
      oth_busy <= own_q != 3'h4;
    end else if (!oth_br_n && !oth_bg_n && bbsy_n) begin
      oth_busy <= 1'b1;
      oth_br_n <= 1'b1;
      own_q <= 3'h0;
    end else if (oth_go) begin
      oth_br_n <= 1'b0;
    end
  end
endmodule : vmi_bus_partner

// ### vmi_consts.svh
`ifndef VMI_CONSTS_SVH
`define VMI_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and bus timing
// ----------------------------------------------------------------------------
`define VMI_CLK_MHZ 25
`define VMI_T_ADDR_SETUP_NS 35
`define VMI_ADDR_SETUP_CYC ((`VMI_T_ADDR_SETUP_NS * `VMI_CLK_MHZ + 999) / 1000)
`define VMI_T_BBSY_MIN_NS 90
`define VMI_BBSY_MIN_CYC ((`VMI_T_BBSY_MIN_NS * `VMI_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// Address decode of the processor space
// ----------------------------------------------------------------------------
`define VMI_LOC_MASK 32'hFF80_0000
`define VMI_LOC_BASE 32'h0000_0000
`define VMI_A16_TAG 16'hFFFF
`define VMI_A24_TAG 8'hFF

// ----------------------------------------------------------------------------
// Address modifier codes
// ----------------------------------------------------------------------------
`define VMI_AM_A32 6'h09
`define VMI_AM_A24 6'h39
`define VMI_AM_A16 6'h29

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VMI_RST_STROBE_N 1'b1
`define VMI_RST_LANE 4'hF
`define VMI_RST_GRANT_N 4'hF

`endif

// ### vmi_master.sv
// Behaviour
// R1 - Decode whole 4G space; 8/16/24/32-bit transfers
// R2 - Odd-address 16-bit access is one cycle (code does this at offset 1 only and refuses offset 3 with an error)
// R3 - Drive next address once acknowledge arrives
// R4 - Request bus as soon as access pends
// R5 - Release bus busy early in final cycle
// R6 - Hold bus busy when next access pending
// R7 - Four-level arbiter with three selectable modes
// R8 - Handshakes follow standard bus ordering
`timescale 1ns/1ps
`include "vmi_consts.svh"

module vmi_master
  import vmi_pkg::*;
(
  input wire logic mclk, // System clock, 25 MHz
  input wire logic sys_rst, // Async reset, high
  input wire logic loc_req, // Local access request pulse
  input wire logic [31:0] loc_addr, // Local byte address
  input wire logic loc_wr, // 1 write, 0 read
  input wire logic [1:0] loc_size, // Bytes minus one
  input wire logic [31:0] loc_wdata, // Write data, bus lane placed
  output logic loc_rdy, // Request slot free
  output logic loc_ack, // Access finished pulse
  output logic loc_err, // Finished with error
  output logic [31:0] loc_rdata, // Read data
  input wire logic sysctl_en, // Act as system controller
  input wire logic [1:0] arb_mode, // Arbiter mode
  input wire logic [3:0] arb_br_n, // Bus request lines in
  output logic [3:0] arb_bg_n, // Grant chain starts
  output logic [31:1] vme_a_o, // Address out
  output logic [5:0] vme_am_o, // Address modifier out
  output logic vme_lword_n_o, // Long word select
  output logic vme_write_n_o, // Write select, low
  output logic vme_as_n_o, // Address strobe
  output logic vme_ds0_n_o, // Data strobe 0
  output logic vme_ds1_n_o, // Data strobe 1
  output logic vme_ctl_oe, // Enable for address and strobes
  input wire logic [31:0] vme_d_i, // Data in
  output logic [31:0] vme_d_o, // Data out
  output logic vme_d_oe, // Data drive enable
  input wire logic vme_as_n_i, // Address strobe as seen on bus
  input wire logic vme_dtack_n, // Slave acknowledge
  input wire logic vme_berr_n, // Bus error
  input wire logic vme_bg_in_n, // Grant daisy in
  output logic vme_bg_out_n, // Grant daisy out
  input wire logic vme_br_n_i, // Own request line level
  output logic vme_br_o, // Request line drive value
  output logic vme_br_oe, // Request line pulled low
  input wire logic vme_bbsy_n_i, // Bus busy level
  output logic vme_bbsy_o, // Bus busy drive value
  output logic vme_bbsy_oe // Bus busy pulled low
);

  // ----------------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------------
  // Lane code {ok, lword_n, a1, ds1_n, ds0_n}
  function automatic logic [4:0] lane_f(input logic [1:0] a, input logic [1:0] sz);
    logic [4:0] r;
    r = 5'h00;
    unique case (sz)
      2'd0: r = {1'b1, 1'b1, a[1], a[0], ~a[0]};
      2'd1: r = (a[0] == 1'b0) ? {1'b1, 1'b1, a[1], 2'b00} : (a == 2'd1) ? 5'b1_0000 : 5'h00;
      2'd2: r = (a == 2'd0) ? 5'b1_0001 : (a == 2'd1) ? 5'b1_0010 : 5'h00;
      2'd3: r = (a == 2'd0) ? 5'b1_0000 : 5'h00;
    endcase
    return r;
  endfunction : lane_f

  // R1 full space decode
  wire in_loc = (loc_addr & `VMI_LOC_MASK) == `VMI_LOC_BASE;
  wire is_a16 = loc_addr[31:16] == `VMI_A16_TAG;
  wire is_a24 = !is_a16 && loc_addr[31:24] == `VMI_A24_TAG;
  wire [5:0] am_sel = is_a16 ? `VMI_AM_A16 : (is_a24 ? `VMI_AM_A24 : `VMI_AM_A32);
  // R2 single unaligned cycle
  wire [4:0] lane = lane_f(loc_addr[1:0], loc_size);

  logic pend_v_q;
  logic pend_v_d;
  logic [31:1] pend_a_q;
  logic [5:0] pend_am_q;
  logic [3:0] pend_ln_q;
  logic pend_wr_q;
  logic [31:0] pend_wd_q;

  // Misaligned sizes that would need two cycles are refused with an error
  wire take = loc_req && !pend_v_q && !in_loc;
  wire take_ok = take && lane[4];
  wire take_bad = take && !lane[4];

  // ----------------------------------------------------------------------------
  // Sequencer conditions
  // ----------------------------------------------------------------------------
  vmi_mst_st_t st_q, st_d;
  logic own_q;
  logic own_d;
  logic [3:0] cnt_q;
  logic [3:0] bcnt_q;
  logic cur_wr_q;
  logic vme_ds0_lane_q;
  logic vme_ds1_lane_q;

  wire dtk = !vme_dtack_n;
  wire berr = !vme_berr_n;
  // R8 grant only onto free bus
  wire grant = st_q == VM_ARB && !vme_bg_in_n && vme_bbsy_n_i;
  wire done = st_q == VM_STRB && (dtk || berr);
  // R3 overlap next address
  // A bus given up early must be won again before the next cycle starts
  wire pipe = done && pend_v_q && own_q;
  wire start = (st_q == VM_IDLE && pend_v_q && own_q) || grant || pipe;
  // R8 address setup and slave released
  wire setup_ok = st_q == VM_ADDR && cnt_q == 4'd0 && vme_as_n_i && vme_dtack_n && vme_berr_n;
  // R5 early busy release
  wire drop = own_q && bcnt_q == 4'd0 && !pend_v_q && !take_ok && st_q != VM_ADDR;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      VM_IDLE: if (pend_v_q) st_d = own_q ? VM_ADDR : VM_ARB;
      VM_ARB: if (grant) st_d = VM_ADDR;
      VM_ADDR: if (setup_ok) st_d = VM_STRB;
      VM_STRB: if (done) st_d = pipe ? VM_ADDR : VM_REL;
      VM_REL: if (vme_dtack_n && vme_berr_n) st_d = VM_IDLE;
    endcase
  end

  // R6 keep busy while work pends
  assign own_d = grant ? 1'b1 : (drop ? 1'b0 : own_q);
  assign pend_v_d = take_ok ? 1'b1 : (start ? 1'b0 : pend_v_q);

  // ----------------------------------------------------------------------------
  // Pending slot
  // ----------------------------------------------------------------------------
  // One entry ahead of the bus lets arbitration and pipelining start early
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_v_q <= 1'b0;
      pend_a_q <= '0;
      pend_am_q <= 6'h00;
      pend_ln_q <= `VMI_RST_LANE;
      pend_wr_q <= 1'b0;
      pend_wd_q <= 32'h0000_0000;
    end else begin
      pend_v_q <= pend_v_d;
      if (take_ok) begin
        pend_a_q <= {loc_addr[31:2], lane[2]};
        pend_am_q <= am_sel;
        pend_ln_q <= lane[3:0];
        pend_wr_q <= loc_wr;
        pend_wd_q <= loc_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State, setup counter and ownership
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= VM_IDLE;
      own_q <= 1'b0;
      cnt_q <= 4'd0;
      bcnt_q <= 4'd0;
    end else begin
      st_q <= st_d;
      own_q <= own_d;
      cnt_q <= start ? 4'(`VMI_ADDR_SETUP_CYC - 1) : ((cnt_q != 4'd0) ? cnt_q - 4'd1 : 4'd0);
      bcnt_q <= grant ? 4'(`VMI_BBSY_MIN_CYC - 1) : ((bcnt_q != 4'd0) ? bcnt_q - 4'd1 : 4'd0);
    end
  end

  // ----------------------------------------------------------------------------
  // Bus address, strobes and data
  // ----------------------------------------------------------------------------
  // Address lines keep driving through release; a new owner waits for AS high
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vme_a_o <= '0;
      vme_am_o <= 6'h00;
      vme_lword_n_o <= 1'b1;
      vme_write_n_o <= 1'b1;
      cur_wr_q <= 1'b0;
      vme_d_o <= 32'h0000_0000;
    end else if (start) begin
      vme_a_o <= pend_a_q;
      vme_am_o <= pend_am_q;
      vme_lword_n_o <= pend_ln_q[3];
      vme_write_n_o <= !pend_wr_q;
      cur_wr_q <= pend_wr_q;
      vme_d_o <= pend_wd_q;
    end
  end

  // R8 strobe after setup, release on acknowledge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vme_as_n_o <= `VMI_RST_STROBE_N;
      vme_ds0_n_o <= `VMI_RST_STROBE_N;
      vme_ds1_n_o <= `VMI_RST_STROBE_N;
    end else if (setup_ok) begin
      vme_as_n_o <= 1'b0;
      vme_ds0_n_o <= vme_ds0_lane_q;
      vme_ds1_n_o <= vme_ds1_lane_q;
    end else if (done) begin
      vme_as_n_o <= 1'b1;
      vme_ds0_n_o <= 1'b1;
      vme_ds1_n_o <= 1'b1;
    end
  end

  // Lane strobes of the cycle in flight, kept apart from the pending slot
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vme_ds0_lane_q <= 1'b1;
      vme_ds1_lane_q <= 1'b1;
    end else if (start) begin
      vme_ds0_lane_q <= pend_ln_q[0];
      vme_ds1_lane_q <= pend_ln_q[1];
    end
  end

  // Drive enables follow ownership of the cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vme_ctl_oe <= 1'b0;
      vme_d_oe <= 1'b0;
    end else begin
      vme_ctl_oe <= start ? 1'b1 : ((st_q == VM_REL && st_d == VM_IDLE) ? 1'b0 : vme_ctl_oe);
      vme_d_oe <= start ? pend_wr_q : (done ? 1'b0 : vme_d_oe);
    end
  end

  // ----------------------------------------------------------------------------
  // Arbitration pins
  // ----------------------------------------------------------------------------
  logic od_low_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vme_br_oe <= 1'b0;
      vme_bbsy_oe <= 1'b0;
      vme_bg_out_n <= 1'b1;
      od_low_q <= 1'b0;
    end else begin
      // R4 request ahead of cycle
      vme_br_oe <= pend_v_d && !own_d;
      vme_bbsy_oe <= own_d;
      // R8 pass grant when not requesting
      vme_bg_out_n <= vme_bg_in_n || vme_br_oe || !vme_br_n_i && st_q == VM_ARB;
      od_low_q <= 1'b0;
    end
  end

  assign vme_br_o = od_low_q;
  assign vme_bbsy_o = od_low_q;

  // ----------------------------------------------------------------------------
  // Local answer
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      loc_rdy <= 1'b0;
      loc_ack <= 1'b0;
      loc_err <= 1'b0;
      loc_rdata <= 32'h0000_0000;
    end else begin
      loc_rdy <= !pend_v_d;
      loc_ack <= done || take_bad;
      loc_err <= (done && berr) || take_bad;
      if (done && !cur_wr_q) loc_rdata <= vme_d_i;
    end
  end

  // ----------------------------------------------------------------------------
  // System controller arbiter
  // ----------------------------------------------------------------------------
  // R7 four-level arbiter
  vmi_arbiter u_arb (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .arb_en(sysctl_en),
    .arb_mode(arb_mode),
    .br_n(arb_br_n),
    .bbsy_n(vme_bbsy_n_i),
    .bg_n(arb_bg_n)
  );

endmodule : vmi_master

// ### vmi_master_asserts.sv
`timescale 1ns/1ps

module vmi_master_asserts
  import vmi_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic loc_rdy, // slot free
  input wire logic loc_ack, // done
  input wire logic loc_err, // error
  input wire logic sysctl_en, // arbiter on
  input wire logic [1:0] arb_mode, // arbiter mode
  input wire logic [3:0] arb_bg_n, // grants
  input wire logic vme_as_n_o, // strobe
  input wire logic vme_ctl_oe, // drive enable
  input wire logic vme_dtack_n, // acknowledge
  input wire logic vme_bg_in_n, // grant in
  input wire logic vme_bg_out_n, // grant out
  input wire logic vme_br_oe, // request drive
  input wire logic vme_bbsy_n_i, // busy wire
  input wire logic vme_bbsy_oe // busy drive
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // Ownership and cycle steps
  // ----------------------------------------
  sequence s_grant_seen;
    vme_br_oe && !vme_bg_in_n && vme_bbsy_n_i;
  endsequence
  sequence s_owner;
    vme_bbsy_oe && vme_ctl_oe && !vme_br_oe;
  endsequence
  sequence s_acked;
    !vme_as_n_o && !vme_dtack_n;
  endsequence

  chk_grant_taken: assert property (s_grant_seen |=> s_owner)
    else $error("grant not taken at next edge");
  chk_as_owned: assert property (!vme_as_n_o |-> vme_ctl_oe)
    else $error("strobe low without drive");
  chk_strobe_end: assert property (s_acked |=> vme_as_n_o && loc_ack)
    else $error("strobe or ack wrong after acknowledge");
  chk_bbsy_min: assert property ($rose(vme_bbsy_oe) |-> vme_bbsy_oe [*3])
    else $error("busy held under three cycles");
  chk_bbsy_kept: assert property (s_acked ##0 (vme_bbsy_oe && !loc_rdy) |=> vme_bbsy_oe && vme_ctl_oe)
    else $error("busy dropped with access pending");
  chk_err_ack: assert property (loc_err |-> loc_ack)
    else $error("error without ack");
  chk_one_grant: assert property ($onehot0(~arb_bg_n))
    else $error("two grants at once");
  chk_single_lvl: assert property (sysctl_en && arb_mode == ARB_SGL |-> &arb_bg_n[2:0])
    else $error("low level granted in single mode");
  chk_grant_drop: assert property (!vme_bbsy_n_i && !(&arb_bg_n) |=> &arb_bg_n)
    else $error("grant kept after busy");
  chk_grant_held: assert property (vme_br_oe |=> vme_bg_out_n)
    else $error("grant passed on while requesting");
endmodule : vmi_master_asserts

// ### vmi_pkg.sv
package vmi_pkg;

  // --------------------------------------------------------------------------
  // Master sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    VM_IDLE = 5'b0_0001,
    VM_ARB  = 5'b0_0010,
    VM_ADDR = 5'b0_0100,
    VM_STRB = 5'b0_1000,
    VM_REL  = 5'b1_0000
  } vmi_mst_st_t;

  // --------------------------------------------------------------------------
  // Arbiter states and modes
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    AR_IDLE  = 3'b001,
    AR_GRANT = 3'b010,
    AR_BUSY  = 3'b100
  } vmi_arb_st_t;

  typedef enum logic [1:0] {
    ARB_RR  = 2'h0,
    ARB_PRI = 2'h1,
    ARB_SGL = 2'h2
  } vmi_arb_mode_t;

endpackage : vmi_pkg
